// ===== verilog/cdm_pkg.sv
`default_nettype none
package cdm_pkg;

	// ************************************************************
	// Register window placement
	// ************************************************************
	localparam logic [31:0] CDM_BASE_ADDR = 32'h8100_0000;
	localparam logic [9:0] CDM_OFS_CTRL = 10'h000;
	localparam logic [9:0] CDM_OFS_GPR0_LO = 10'h200;
	localparam logic [9:0] CDM_OFS_GPR0_HI = 10'h27C;
	localparam logic [9:0] CDM_OFS_GPR1_LO = 10'h280;
	localparam logic [9:0] CDM_OFS_GPR1_HI = 10'h2FC;
	localparam logic [9:0] CDM_OFS_SPR_LO = 10'h300;
	localparam logic [9:0] CDM_OFS_SPR_HI = 10'h36C;

	// ************************************************************
	// Control register fields and reset value
	// ************************************************************
	localparam int CDM_BIT_DEBUG_MODE = 0;
	localparam int CDM_BIT_UART_SEL = 1;
	localparam int CDM_BIT_SPACEWIRE_PORT0_DEBUG_SELECT_SEL = 2;
	localparam int CDM_BIT_SPACEWIRE_PORT1_DEBUG_SELECT_SEL = 3;
	localparam logic [3:0] CDM_CTRL_RESET = 4'h2;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CDM_SYNC_STAGES = 2;
	// Cycles the core is held after reset while the halt pin settles
	localparam logic [1:0] CDM_BOOT_HOLD_CYCLES = 2'h3;

	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [1:0]
	{
		CDM_SPACE_NONE,
		CDM_SPACE_GPR0,
		CDM_SPACE_GPR1,
		CDM_SPACE_SPR
	} cdm_space_t;

	typedef struct packed
	{
		logic write;
		cdm_space_t space;
		logic [4:0] index;
		logic [31:0] wdata;
	} cdm_core_req_t;

endpackage
`default_nettype wire

// ===== verilog/cdm_halt_sync.sv
`timescale 1ns/100ps
`default_nettype none
module cdm_halt_sync
	import cdm_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	// Raw pin
	input wire logic pin_in,
	// Synchronised level and edges
	output logic level_out,
	output logic rise_out,
	output logic fall_out
);

	logic meta;
	logic stable;
	logic prev;

	// Two-flop synchroniser, then one flop for edge detection
	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			meta <= 1'b0;
			stable <= 1'b0;
			prev <= 1'b0;
		end
		else
		begin
			meta <= pin_in;
			stable <= meta;
			prev <= stable;
		end
	end

	// Edges taken from the synchronised level only
	assign level_out = stable;
	assign rise_out = stable & ~prev;
	assign fall_out = ~stable & prev;

	a_rise_edge: assert property (@(posedge sys_clk_in)
		disable iff (!rst_n_in) rise_out |-> level_out && !$past(stable))
		else $error("rise pulse without a low to high change");

endmodule
`default_nettype wire

// ===== verilog/cdm_debug_unit.sv
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Debug mode holds the core fully idle
// - Halt pin rising edge enters debug mode
// - Software writing one enters debug mode
// - Halt pin falling edge or write zero exits
// - Write zero ignored while halt pin high
// - Halt high at reset enters debug as the boot hold ends
// - Selected bus masters reach core in debug
// - Control register layout, offset zero, resets
// - UART select bit gates UART debug access
// - SpaceWire select bits gate each port
// - GPR banks at 0x200 and 0x280
// - Special registers at 0x300 to 0x36C
// - Core registers only in debug; control always
// - Window answers at base 0x8100_0000
// - Unused upper bits read zero, writes ignored
// - Pipeline drains before core halts
// - Core resumes after last completed instruction
module cdm_debug_unit
	import cdm_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	// External halt request pin
	input wire logic halt_pin_in,
	// Peripheral bus slave
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [31:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// Core control
	output logic core_halt_out,
	input wire logic core_halted_in,
	// Core register access port
	output logic core_req_valid_out,
	output cdm_core_req_t core_req_out,
	input wire logic core_ack_in,
	input wire logic [31:0] core_rdata_in,
	// Debug master permissions
	output logic uart_debug_en_out,
	output logic spacewire_port0_debug_en_out,
	output logic spacewire_port1_debug_en_out,
	output logic debug_active_out
);

	// ************************************************************
	// Address decoding
	// ************************************************************

	// Maps a window offset to a core register space
	function automatic cdm_space_t decode_space(input logic [9:0] ofs);
		if (ofs >= CDM_OFS_GPR0_LO && ofs <= CDM_OFS_GPR0_HI)
			decode_space = CDM_SPACE_GPR0;
		else if (ofs >= CDM_OFS_GPR1_LO && ofs <= CDM_OFS_GPR1_HI)
			decode_space = CDM_SPACE_GPR1;
		else if (ofs >= CDM_OFS_SPR_LO && ofs <= CDM_OFS_SPR_HI)
			decode_space = CDM_SPACE_SPR;
		else
			decode_space = CDM_SPACE_NONE;
	endfunction

	logic hold_level;
	logic hold_rise;
	logic hold_fall;
	logic debug_mode_bit;
	logic uart_debug_select;
	logic spacewire_port0_debug_select;
	logic spacewire_port1_debug_select;
	logic [1:0] boot_count;
	logic done;
	logic err;
	logic in_window;
	logic aligned;
	logic is_ctrl;
	cdm_space_t space;
	logic is_core;
	logic access;
	logic core_allowed;
	logic ctrl_write;

	// Window hit on base address and word alignment
	assign in_window = paddr_in[31:10] == CDM_BASE_ADDR[31:10];
	assign aligned = paddr_in[1:0] == 2'h0;
	assign space = decode_space(paddr_in[9:0]);
	assign is_ctrl = in_window && paddr_in[9:0] == CDM_OFS_CTRL;
	assign is_core = in_window && aligned && space != CDM_SPACE_NONE;
	assign access = psel_in && penable_in && !done;
	// Core registers only once the core has drained and stopped
	assign core_allowed = debug_mode_bit && core_halted_in;
	assign ctrl_write = access && is_ctrl && pwrite_in;

	// ************************************************************
	// Halt pin synchroniser
	// ************************************************************
	cdm_halt_sync u_halt_sync
	(
		.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_in),
		.pin_in(halt_pin_in),
		.level_out(hold_level),
		.rise_out(hold_rise),
		.fall_out(hold_fall)
	);

	// ************************************************************
	// Debug mode state
	// ************************************************************

	// Entry by pin edge or write of one; entry wins over a clear
	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			debug_mode_bit <= CDM_CTRL_RESET[CDM_BIT_DEBUG_MODE];
		else if (hold_rise)
			debug_mode_bit <= 1'b1;
		else if (ctrl_write && pwdata_in[CDM_BIT_DEBUG_MODE])
			debug_mode_bit <= 1'b1;
		else if (hold_fall)
			debug_mode_bit <= 1'b0;
		else if (ctrl_write && !hold_level)
			debug_mode_bit <= 1'b0;
	end

	// Master select bits; bits above 3 are not stored
	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			uart_debug_select <= CDM_CTRL_RESET[CDM_BIT_UART_SEL];
			spacewire_port0_debug_select <= CDM_CTRL_RESET[CDM_BIT_SPACEWIRE_PORT0_DEBUG_SELECT_SEL];
			spacewire_port1_debug_select <= CDM_CTRL_RESET[CDM_BIT_SPACEWIRE_PORT1_DEBUG_SELECT_SEL];
		end
		else if (ctrl_write)
		begin
			uart_debug_select <= pwdata_in[CDM_BIT_UART_SEL];
			spacewire_port0_debug_select <= pwdata_in[CDM_BIT_SPACEWIRE_PORT0_DEBUG_SELECT_SEL];
			spacewire_port1_debug_select <= pwdata_in[CDM_BIT_SPACEWIRE_PORT1_DEBUG_SELECT_SEL];
		end
	end

	// Keeps the core stopped until a pin held at reset is seen
	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			boot_count <= CDM_BOOT_HOLD_CYCLES;
		else if (boot_count != 2'h0)
			boot_count <= boot_count - 2'h1;
	end

	// Halt is a level; the core drains its pipeline and resumes itself
	assign core_halt_out = debug_mode_bit || boot_count != 2'h0;
	assign debug_active_out = debug_mode_bit;
	assign uart_debug_en_out = debug_mode_bit && uart_debug_select;
	assign spacewire_port0_debug_en_out =
		debug_mode_bit && spacewire_port0_debug_select;
	assign spacewire_port1_debug_en_out =
		debug_mode_bit && spacewire_port1_debug_select;

	// ************************************************************
	// Bus answer
	// ************************************************************

	// Core access request while the bus waits
	assign core_req_valid_out = access && is_core && core_allowed;
	assign core_req_out.write = pwrite_in;
	assign core_req_out.space = space;
	assign core_req_out.index = paddr_in[6:2];
	assign core_req_out.wdata = pwdata_in;

	// Finishes an access one cycle after it is decided
	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			done <= 1'b0;
			err <= 1'b0;
			prdata_out <= 32'h0000_0000;
		end
		else if (done)
		begin
			done <= 1'b0;
			err <= 1'b0;
		end
		else if (access && is_ctrl)
		begin
			done <= 1'b1;
			prdata_out <= {28'h000_0000, spacewire_port1_debug_select,
				spacewire_port0_debug_select, uart_debug_select,
				debug_mode_bit};
		end
		else if (access && is_core && core_allowed)
		begin
			if (core_ack_in)
			begin
				done <= 1'b1;
				prdata_out <= pwrite_in ? 32'h0000_0000 : core_rdata_in;
			end
		end
		else if (access)
		begin
			// Unmapped, or core register unless halted in debug mode
			done <= 1'b1;
			err <= 1'b1;
			prdata_out <= 32'h0000_0000;
		end
	end

	assign pready_out = done;
	assign pslverr_out = done && err;

	// ************************************************************
	// Checks
	// ************************************************************
	a_halt_in_debug: assert property (@(posedge sys_clk_in)
		disable iff (!rst_n_in) debug_mode_bit |-> core_halt_out)
		else $error("core not halted in debug mode");

	a_pin_enters: assert property (@(posedge sys_clk_in)
		disable iff (!rst_n_in) hold_rise |=> debug_mode_bit)
		else $error("pin rise did not enter debug mode");

	a_sw_enters: assert property (@(posedge sys_clk_in)
		disable iff (!rst_n_in)
		ctrl_write && pwdata_in[0] |=> debug_mode_bit)
		else $error("write of one did not enter debug mode");

	a_pin_exits: assert property (@(posedge sys_clk_in)
		disable iff (!rst_n_in)
		hold_fall && !(ctrl_write && pwdata_in[0]) |=> !debug_mode_bit)
		else $error("pin fall did not leave debug mode");

	a_clear_blocked: assert property (@(posedge sys_clk_in)
		disable iff (!rst_n_in)
		debug_mode_bit && hold_level && !hold_fall |=> debug_mode_bit)
		else $error("debug mode left while halt pin high");

	// Only a pin already high as the hold ends counts as held at reset
	a_boot_hold: assert property (@(posedge sys_clk_in)
		disable iff (!rst_n_in)
		$rose(boot_count == 2'h0) && hold_level && $past(hold_level)
		|-> debug_mode_bit)
		else $error("halt at reset did not reach debug mode");

	a_uart_gate: assert property (@(posedge sys_clk_in)
		disable iff (!rst_n_in)
		uart_debug_en_out |-> uart_debug_select && debug_mode_bit)
		else $error("uart debug enabled without select");

	a_core_gate: assert property (@(posedge sys_clk_in)
		disable iff (!rst_n_in)
		core_req_valid_out |-> debug_mode_bit && space != CDM_SPACE_NONE
		&& in_window)
		else $error("core access outside debug mode or window");

	a_ctrl_read: assert property (@(posedge sys_clk_in)
		disable iff (!rst_n_in)
		access && is_ctrl |=> pready_out && !pslverr_out
		&& prdata_out[31:4] == 28'h000_0000)
		else $error("control register answer wrong");

	a_base_check: assert property (@(posedge sys_clk_in)
		disable iff (!rst_n_in)
		access && paddr_in[31:10] != CDM_BASE_ADDR[31:10] |=> pslverr_out)
		else $error("access outside window not refused");

endmodule
`default_nettype wire

// ===== tb/cdm_core_model.sv
`timescale 1ns/100ps
`default_nettype none
module cdm_core_model
	import cdm_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	// Halt handshake
	input wire logic halt_in,
	output logic halted_out,
	// Register access
	input wire logic slow_in,
	input wire logic req_valid_in,
	input wire cdm_core_req_t req_in,
	output logic ack_out,
	output logic [31:0] rdata_out
);
	// ************************************************************
	// Core stand-in
	// ************************************************************
	logic [31:0] mem [0:127];
	logic [1:0] drain;
	logic [2:0] wait_cnt;

	// Pipeline drains for two cycles, then the core reports halted
	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			drain <= 2'h0;
			halted_out <= 1'b0;
		end
		else
		begin
			drain <= halt_in ? {drain[0], 1'b1} : 2'h0;
			halted_out <= halt_in & drain[1];
		end
	end

	// Register file storage
	always_ff @(posedge sys_clk_in)
		if (req_valid_in && req_in.write)
			mem[{req_in.space, req_in.index}] <= req_in.wdata;

	// Answer promptly or after a stall; data toggles in every cycle without an answer
	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			wait_cnt <= 3'h0;
			ack_out <= 1'b0;
			rdata_out <= 32'h0;
		end
		else if (req_valid_in && !ack_out &&
			wait_cnt >= (slow_in ? 3'h4 : 3'h0))
		begin
			ack_out <= 1'b1;
			wait_cnt <= 3'h0;
			rdata_out <= mem[{req_in.space, req_in.index}];
		end
		else
		begin
			ack_out <= 1'b0;
			wait_cnt <= req_valid_in ? wait_cnt + 3'h1 : 3'h0;
			rdata_out <= ~rdata_out;
		end
	end
endmodule
`default_nettype wire

// ===== tb/chip_debug_mode_unit_tb.sv
`timescale 1ns/100ps
`default_nettype none
module chip_debug_mode_unit_tb import cdm_pkg::*; ;
	// ************************************************************
	// Bench
	// ************************************************************
	typedef struct packed
	{
		logic wr;
		logic [9:0] ofs;
		logic [31:0] wd;
		logic [31:0] rd;
		logic err;
		logic [3:0] en;
	} cdm_tb_row_t;
	logic sys_clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic halt_pin_in = 1'b0;
	logic psel_in = 1'b0;
	logic penable_in = 1'b0;
	logic pwrite_in = 1'b0;
	logic slow = 1'b0;
	logic [31:0] paddr_in = 32'h0;
	logic [31:0] pwdata_in = 32'h0;
	logic [31:0] prdata_out, core_rdata_in, rd;
	logic pready_out, pslverr_out, core_halt_out, core_halted_in, err;
	logic core_req_valid_out, core_ack_in, debug_active_out;
	logic uart_debug_en_out, spacewire_port0_debug_en_out;
	logic spacewire_port1_debug_en_out;
	cdm_core_req_t core_req_out;
	int num_errors = 0;
	int samples_checked = 0;
	wire [3:0] en = {debug_active_out, uart_debug_en_out,
		spacewire_port0_debug_en_out, spacewire_port1_debug_en_out};
	// A control write answers with the register's contents before it
	cdm_tb_row_t rows [16] = '{
		'{1'b0, 10'h000, 32'h0, 32'h2, 1'b0, 4'h0},
		'{1'b0, 10'h200, 32'h0, 32'h0, 1'b1, 4'h0},
		'{1'b1, 10'h000, 32'hFFFFFFF5, 32'h2, 1'b0, 4'hA},
		'{1'b0, 10'h000, 32'h0, 32'h5, 1'b0, 4'hA},
		'{1'b1, 10'h27C, 32'hA5A50001, 32'h0, 1'b0, 4'hA},
		'{1'b0, 10'h27C, 32'h0, 32'hA5A50001, 1'b0, 4'hA},
		'{1'b1, 10'h280, 32'h12345678, 32'h0, 1'b0, 4'hA},
		'{1'b0, 10'h280, 32'h0, 32'h12345678, 1'b0, 4'hA},
		'{1'b1, 10'h36C, 32'hCAFE0036, 32'h0, 1'b0, 4'hA},
		'{1'b0, 10'h36C, 32'h0, 32'hCAFE0036, 1'b0, 4'hA},
		'{1'b0, 10'h370, 32'h0, 32'h0, 1'b1, 4'hA},
		'{1'b0, 10'h202, 32'h0, 32'h0, 1'b1, 4'hA},
		'{1'b0, 10'h100, 32'h0, 32'h0, 1'b1, 4'hA},
		'{1'b1, 10'h000, 32'h0000000A, 32'h5, 1'b0, 4'h0},
		'{1'b0, 10'h36C, 32'h0, 32'h0, 1'b1, 4'h0},
		'{1'b0, 10'h000, 32'h0, 32'hA, 1'b0, 4'h0}};

	// Clock at 100 MHz
	always #5 sys_clk_in = ~sys_clk_in;

	cdm_debug_unit DUT
	(
		.sys_clk_in, .rst_n_in, .halt_pin_in, .psel_in, .penable_in,
		.pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out,
		.pslverr_out, .core_halt_out, .core_halted_in,
		.core_req_valid_out, .core_req_out, .core_ack_in,
		.core_rdata_in, .uart_debug_en_out, .spacewire_port0_debug_en_out,
		.spacewire_port1_debug_en_out, .debug_active_out
	);

	cdm_core_model core
	(
		.sys_clk_in, .rst_n_in, .halt_in(core_halt_out),
		.halted_out(core_halted_in), .slow_in(slow),
		.req_valid_in(core_req_valid_out), .req_in(core_req_out),
		.ack_out(core_ack_in), .rdata_out(core_rdata_in)
	);

	task automatic check(input string name, input logic [31:0] got, exp);
		samples_checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask

	// One bus access, entered and left at a falling edge
	task automatic apb(input logic wr, input logic [9:0] ofs,
		input logic [31:0] wd, output logic [31:0] rdv, output logic e);
		int n;
		psel_in = 1'b1;
		pwrite_in = wr;
		paddr_in = CDM_BASE_ADDR | {22'h0, ofs};
		pwdata_in = wd;
		@(negedge sys_clk_in);
		penable_in = 1'b1;
		n = 0;
		do
		begin
			@(posedge sys_clk_in);
			n++;
		end
		while (pready_out !== 1'b1 && n < 40);
		rdv = prdata_out;
		e = pslverr_out;
		check("answer", {31'h0, pready_out}, 32'h1);
		@(negedge sys_clk_in);
		psel_in = 1'b0;
		penable_in = 1'b0;
		@(negedge sys_clk_in);
	endtask

	task automatic report_and_stop();
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Watchdog
	initial
	begin
		repeat (4000) @(posedge sys_clk_in);
		num_errors++;
		report_and_stop();
	end

	// Table of accesses, then hand-written cases
	initial
	begin
		repeat (20) @(negedge sys_clk_in);
		check("reset_halt", {31'h0, core_halt_out}, 32'h1);
		check("reset_en", {28'h0, en}, 32'h0);
		rst_n_in = 1'b1;
		foreach (rows[i])
		begin
			slow = i[0];
			apb(rows[i].wr, rows[i].ofs, rows[i].wd, rd, err);
			check("rdata", rd, rows[i].rd);
			check("slverr", {31'h0, err}, {31'h0, rows[i].err});
			check("enables", {28'h0, en}, {28'h0, rows[i].en});
		end
		// Debugger holds the pin high for the whole session
		halt_pin_in = 1'b1;
		@(negedge sys_clk_in);
		check("sync_delay", {31'h0, debug_active_out}, 32'h0);
		repeat (4) @(negedge sys_clk_in);
		check("pin_enter", {31'h0, debug_active_out}, 32'h1);
		check("debug_halt", {31'h0, core_halt_out}, 32'h1);
		apb(1'b1, CDM_OFS_CTRL, 32'h0, rd, err);
		apb(1'b0, CDM_OFS_CTRL, 32'h0, rd, err);
		check("zero_ignored", rd, 32'h1);
		apb(1'b0, CDM_OFS_SPR_LO, 32'h0, rd, err);
		check("pin_access", {31'h0, err}, 32'h0);
		halt_pin_in = 1'b0;
		repeat (5) @(negedge sys_clk_in);
		check("pin_exit", {31'h0, debug_active_out}, 32'h0);
		check("resume", {31'h0, core_halt_out}, 32'h0);
		apb(1'b1, CDM_OFS_CTRL, 32'hF, rd, err);
		check("all_masters", {28'h0, en}, 32'hF);
		apb(1'b1, CDM_OFS_CTRL, 32'hE, rd, err);
		check("write_exit", {28'h0, en}, 32'h0);
		halt_pin_in = 1'b1;
		rst_n_in = 1'b0;
		repeat (3) @(negedge sys_clk_in);
		rst_n_in = 1'b1;
		repeat (10)
		begin
			@(negedge sys_clk_in);
			check("boot_hold", {31'h0, core_halt_out}, 32'h1);
		end
		check("boot_debug", {31'h0, debug_active_out}, 32'h1);
		apb(1'b0, CDM_OFS_CTRL, 32'h0, rd, err);
		check("boot_ctrl", rd, 32'h3);
		report_and_stop();
	end
endmodule
`default_nettype wire
